// ===== tprf_block.sv
`timescale 1ns/1ps
// Summary of operation
// R01: 256 nine-bit words, one read, one write
// R02: RAM or queue; each port sync/async
// R03: RAM mode: bit eight carries parity
// R04: Odd select high odd, low even
// R05: Read and write parity fault outputs
// R06: Generate mode replaces bit eight with parity
// R07: Sync ports timed by own port clocks
// R08: Reader asserts select, strobe, gives address
// R09: Writer asserts select, strobe, gives word
// R10: Pointer reset empties the queue
// R11: Full ignores writes, empty ignores reads
// R12: Equal flag when count equals threshold
// R13: At-or-above flag when count reaches threshold
// R14: Depth is two to power select+1
// R15: Output mux selects cascaded block word
// R16: Same-location collision returns write data
// R17: Transparent read updates in access cycle
// R18: Pipelined read updates after second edge
// R19: Count up on write, down on read
// R20: Full at depth, empty at zero
module tprf_block (
  input  wire logic        SYS_CLK_IN,
  input  wire logic        NRST_IN,
  input  wire logic        PSEL_IN,
  input  wire logic        PENABLE_IN,
  input  wire logic        PWRITE_IN,
  input  wire logic [11:0] PADDR_IN,
  input  wire logic [31:0] PWDATA_IN,
  output logic      [31:0] PRDATA_OUT,
  output logic             PREADY_OUT,
  output logic             PSLVERR_OUT,
  input  wire logic        WRITE_SIDE_CLOCK_IN,
  input  wire logic        READ_SIDE_CLOCK_IN,
  input  wire logic        WRITE_SELECT_N_IN,
  input  wire logic        WRITE_STROBE_N_IN,
  input  wire logic [7:0]  WRITE_LOCATION_IN,
  input  wire logic [8:0]  WRITE_WORD_IN,
  input  wire logic        READ_SELECT_N_IN,
  input  wire logic        READ_STROBE_N_IN,
  input  wire logic [7:0]  READ_LOCATION_IN,
  input  wire logic        POINTER_RESET_N_IN,
  input  wire logic [8:0]  CASCADE_WORD_IN,
  output logic      [8:0]  READ_WORD_OUT,
  output logic             READ_PARITY_FAULT_OUT,
  output logic             WRITE_PARITY_FAULT_OUT,
  output logic             FULL_OUT,
  output logic             EMPTY_OUT,
  output logic             COUNT_AT_THRESHOLD_OUT,
  output logic             COUNT_AT_OR_ABOVE_THRESHOLD_OUT
);

  ////////////////////////////////////////////////////////////////////////////
  // Helpers
  // Parity bit that makes the nine-bit word match the chosen sense
  function automatic logic par_bit(input logic [7:0] d, input logic odd);
    par_bit = (^d) ^ odd;   // R04
  endfunction

  // Mismatch between a stored or incoming word and the chosen sense
  function automatic logic par_err(input logic [8:0] d, input logic odd);
    par_err = (^d) ^ odd;   // R04
  endfunction

  // Configured queue depth, 2..256 words
  function automatic logic [8:0] depth_of(input logic [2:0] lg);
    depth_of = 9'h002 << lg;   // R14
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // State
  logic [31:0] cfg_ff;            // Configuration register
  logic [31:0] prdata_ff;         // Bus read data
  logic        pready_ff;         // Bus ready
  logic        pslverr_ff;        // Bus error
  logic        wclk_q_ff;         // Write clock, last cycle
  logic        rclk_q_ff;         // Read clock, last cycle
  logic        wact_q_ff;         // Write request, last cycle
  logic        ract_q_ff;         // Read request, last cycle
  logic [7:0]  wptr_ff;           // Queue write pointer
  logic [7:0]  rptr_ff;           // Queue read pointer
  logic [8:0]  cnt_ff;            // Queue occupancy
  logic [8:0]  nxt_cnt;
  logic        rd_vld_ff;         // Array word arrives this cycle
  logic [8:0]  pipe_ff;           // Pipeline stage
  logic        pend_ff;           // Pipeline holds undelivered word
  logic [8:0]  own_ff;            // This block's last read word
  logic [8:0]  nxt_own;
  logic [8:0]  dout_ff;           // Output after cascade mux
  logic        rpe_ff;
  logic        wpe_ff;
  logic        full_ff;
  logic        empty_ff;
  logic        eq_ff;
  logic        geq_ff;

  tprf_mem_if mem_if ();

  tprf_mem u_mem (
    .clk_in   (SYS_CLK_IN),
    .rst_n_in (NRST_IN),
    .port     (mem_if.mem)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Configuration decode
  wire       fifo_mode = cfg_ff[tprf_pkg::CFG_FIFO];        // R02
  wire       wsync     = cfg_ff[tprf_pkg::CFG_WSYNC];       // R02
  wire       rsync     = cfg_ff[tprf_pkg::CFG_RSYNC];       // R02
  wire       pipe_mode = rsync & cfg_ff[tprf_pkg::CFG_PIPE];
  wire       pgen      = cfg_ff[tprf_pkg::CFG_PGEN];
  wire       odd       = cfg_ff[tprf_pkg::CFG_ODD];
  wire       casc      = cfg_ff[tprf_pkg::CFG_CASC];
  wire [2:0] depth_sel = cfg_ff[tprf_pkg::CFG_LG +: 3];
  wire [7:0] level     = cfg_ff[tprf_pkg::CFG_LVL +: 8];
  wire [8:0] depth     = depth_of(depth_sel);
  wire [7:0] ptr_mask  = 8'(depth - 9'h001);

  ////////////////////////////////////////////////////////////////////////////
  // Port requests; async ports act once per strobe assertion
  wire w_act   = ~WRITE_SELECT_N_IN & ~WRITE_STROBE_N_IN;  // R09
  wire r_act   = ~READ_SELECT_N_IN & ~READ_STROBE_N_IN;    // R08
  wire wr_rise = WRITE_SIDE_CLOCK_IN & ~wclk_q_ff;
  wire rd_rise = READ_SIDE_CLOCK_IN & ~rclk_q_ff;
  wire wr_evt  = w_act & (wsync ? wr_rise : ~wact_q_ff);   // R07
  wire rd_evt  = r_act & (rsync ? rd_rise : ~ract_q_ff);   // R07
  wire q_full  = (cnt_ff == depth);
  wire q_empty = (cnt_ff == 9'h000);
  wire wr_ok   = wr_evt & ~(fifo_mode & q_full);           // R11
  wire rd_ok   = rd_evt & ~(fifo_mode & q_empty);          // R11

  // Edge history for the port clocks and strobes
  always_ff @(posedge SYS_CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      wclk_q_ff <= 1'b0;
      rclk_q_ff <= 1'b0;
      wact_q_ff <= 1'b0;
      ract_q_ff <= 1'b0;
    end else begin
      wclk_q_ff <= WRITE_SIDE_CLOCK_IN;
      rclk_q_ff <= READ_SIDE_CLOCK_IN;
      wact_q_ff <= w_act;
      ract_q_ff <= r_act;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Array access; queue mode uses pointers, RAM mode the pins
  assign mem_if.we    = wr_ok;                                           // R01
  assign mem_if.re    = rd_ok;                                           // R01
  assign mem_if.write_location = fifo_mode ? wptr_ff : WRITE_LOCATION_IN;
  assign mem_if.read_location = fifo_mode ? rptr_ff : READ_LOCATION_IN;
  // Generated parity overwrites whatever the writer put on bit eight
  assign mem_if.wdata = pgen ? {par_bit(WRITE_WORD_IN[7:0], odd), WRITE_WORD_IN[7:0]} // R06
                             : WRITE_WORD_IN;                            // R03

  ////////////////////////////////////////////////////////////////////////////
  // Queue pointers
  always_ff @(posedge SYS_CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      wptr_ff <= 8'h00;
      rptr_ff <= 8'h00;
    end else if (!POINTER_RESET_N_IN) begin
      wptr_ff <= 8'h00;   // R10
      rptr_ff <= 8'h00;   // R10
    end else begin
      if (fifo_mode && wr_ok) begin
        wptr_ff <= (wptr_ff + 8'h01) & ptr_mask;   // R14
      end
      if (fifo_mode && rd_ok) begin
        rptr_ff <= (rptr_ff + 8'h01) & ptr_mask;   // R14
      end
    end
  end

  // Occupancy; a write and a read together leave it unchanged
  always_comb begin
    nxt_cnt = cnt_ff;
    if (!POINTER_RESET_N_IN) begin
      nxt_cnt = 9'h000;   // R10
    end else if (fifo_mode) begin
      if (wr_ok && !rd_ok) begin
        nxt_cnt = cnt_ff + 9'h001;   // R19
      end else if (rd_ok && !wr_ok) begin
        nxt_cnt = cnt_ff - 9'h001;   // R19
      end
    end
  end

  always_ff @(posedge SYS_CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      cnt_ff <= 9'h000;
    end else begin
      cnt_ff <= nxt_cnt;
    end
  end

  // Flags follow occupancy one cycle later
  always_ff @(posedge SYS_CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      full_ff  <= 1'b0;
      empty_ff <= 1'b1;
      eq_ff    <= 1'b1;   // Count zero meets level zero
      geq_ff   <= 1'b1;
    end else begin
      full_ff  <= q_full;                     // R20
      empty_ff <= q_empty;                    // R20
      eq_ff    <= (cnt_ff == {1'b0, level});  // R12
      geq_ff   <= (cnt_ff >= {1'b0, level});  // R13
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Parity faults, held until the next access on that port
  always_ff @(posedge SYS_CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      wpe_ff <= 1'b0;
      rpe_ff <= 1'b0;
    end else begin
      if (wr_ok) begin
        wpe_ff <= ~pgen & par_err(WRITE_WORD_IN, odd);   // R05
      end
      if (rd_vld_ff) begin
        rpe_ff <= ~pgen & par_err(mem_if.rdata, odd);    // R05
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data path
  always_ff @(posedge SYS_CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      rd_vld_ff <= 1'b0;
      pipe_ff   <= 9'h000;
      pend_ff   <= 1'b0;
    end else begin
      rd_vld_ff <= rd_ok;
      // Pipelined word waits for the next read clock edge
      if (rd_vld_ff && pipe_mode) begin
        pipe_ff <= mem_if.rdata;   // R18
        pend_ff <= 1'b1;
      end else if (rd_rise) begin
        pend_ff <= 1'b0;
      end
    end
  end

  // Own word: transparent as soon as read, pipelined at next edge
  always_comb begin
    nxt_own = own_ff;
    if (rd_vld_ff && !pipe_mode) begin
      nxt_own = mem_if.rdata;   // R17
    end else if (pipe_mode && pend_ff && rd_rise) begin
      nxt_own = pipe_ff;        // R18
    end
  end

  // Cascade mux keeps own word so switching back loses nothing
  always_ff @(posedge SYS_CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      own_ff  <= 9'h000;
      dout_ff <= 9'h000;
    end else begin
      own_ff  <= nxt_own;
      dout_ff <= casc ? CASCADE_WORD_IN : nxt_own;   // R15
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register bus, one wait state so every answer comes from a flop
  wire acc     = PSEL_IN & PENABLE_IN;
  wire hit_cfg = (PADDR_IN == tprf_pkg::CFG_OFS);
  wire hit_st  = (PADDR_IN == tprf_pkg::STAT_OFS);
  wire [31:0] stat_word = {7'h00, cnt_ff, 10'h000, wpe_ff, rpe_ff,
                           geq_ff, eq_ff, empty_ff, full_ff};

  always_ff @(posedge SYS_CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff  <= 32'h0000_0000;
    end else begin
      pready_ff  <= acc & ~pready_ff;
      pslverr_ff <= acc & ~pready_ff & ~(hit_cfg | hit_st);
      if (acc && !pready_ff && !PWRITE_IN) begin
        prdata_ff <= hit_cfg ? cfg_ff : (hit_st ? stat_word : 32'h0000_0000);
      end
    end
  end

  // Configuration write lands at the completing edge only
  always_ff @(posedge SYS_CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      cfg_ff <= tprf_pkg::CFG_RST;
    end else if (acc && pready_ff && PWRITE_IN && hit_cfg) begin
      cfg_ff <= PWDATA_IN;   // R02
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign PRDATA_OUT                      = prdata_ff;
  assign PREADY_OUT                      = pready_ff;
  assign PSLVERR_OUT                     = pslverr_ff;
  assign READ_WORD_OUT                   = dout_ff;
  assign READ_PARITY_FAULT_OUT           = rpe_ff;
  assign WRITE_PARITY_FAULT_OUT          = wpe_ff;
  assign FULL_OUT                        = full_ff;
  assign EMPTY_OUT                       = empty_ff;
  assign COUNT_AT_THRESHOLD_OUT          = eq_ff;
  assign COUNT_AT_OR_ABOVE_THRESHOLD_OUT = geq_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge SYS_CLK_IN); endclocking
  default disable iff (!NRST_IN);

  sequence s_tread;
    rd_ok && !pipe_mode && !casc && POINTER_RESET_N_IN;
  endsequence
  sequence s_cfg_hold;
    $stable(cfg_ff) [*3];
  endsequence

  a_full_drop_write: assert property (fifo_mode && q_full && wr_evt && !rd_ok // R11
    && POINTER_RESET_N_IN |=> $stable(wptr_ff) && $stable(cnt_ff))
    else $error("Write accepted while full");
  a_empty_drop_read: assert property (fifo_mode && q_empty && rd_evt && !wr_ok // R11
    && POINTER_RESET_N_IN |=> $stable(rptr_ff) && $stable(cnt_ff))
    else $error("Read accepted while empty");
  a_count_up: assert property (fifo_mode && POINTER_RESET_N_IN && wr_ok && !rd_ok // R19
    |=> cnt_ff == $past(cnt_ff) + 9'h001)
    else $error("Count did not rise on write");
  a_count_hold: assert property (fifo_mode && POINTER_RESET_N_IN && wr_ok && rd_ok // R19
    |=> $stable(cnt_ff))
    else $error("Count moved on write with read");
  a_ptr_reset: assert property (!POINTER_RESET_N_IN |=> cnt_ff == 9'h000 ##1 EMPTY_OUT) // R10
    else $error("Pointer reset did not empty queue");
  a_full_flag: assert property (##1 FULL_OUT // R20
    == ($past(cnt_ff) == depth_of($past(depth_sel))))
    else $error("Full flag wrong");
  a_thresh_eq: assert property (##1 COUNT_AT_THRESHOLD_OUT == ($past(cnt_ff) == $past(level))) // R12
    else $error("Equal threshold flag wrong");
  a_thresh_geq: assert property (##1 COUNT_AT_OR_ABOVE_THRESHOLD_OUT // R13
    == ($past(cnt_ff) >= $past(level)))
    else $error("At or above threshold flag wrong");
  a_parity_gen: assert property (pgen && mem_if.we |-> mem_if.wdata[8] // R06
    == ((^WRITE_WORD_IN[7:0]) ^ odd))
    else $error("Generated parity bit wrong");
  a_write_fault: assert property (wr_ok && !pgen && ((^WRITE_WORD_IN) ^ odd) // R05
    |=> WRITE_PARITY_FAULT_OUT)
    else $error("Write parity fault missed");
  a_trans_read: assert property (s_tread ##0 s_cfg_hold |-> READ_WORD_OUT // R17
    == $past(mem_if.rdata))
    else $error("Transparent read word late or wrong");

endmodule

// ===== tprf_block_tb_top.sv
`timescale 1ns/1ps
// Self-checking bench: APB set-up, both ports through the user model
module tprf_block_tb_top;
  logic        clk, rst_n, ptr_rst_n;          // Clock, resets active low
  logic        psel, penable, pwrite;          // APB request
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic        pready, pslverr;
  logic        wsel_n, wstb_n, wclk, rsel_n, rstb_n, rclk;  // Port lines
  logic [7:0]  wloc, rloc;
  logic [8:0]  word, casc, rword;
  logic        rpf, wpf, full, empty, eq, geq; // Status pins
  logic [31:0] q;                              // Last APB read word
  logic        e;                              // Last APB error
  logic [8:0]  wv [4];                         // Words for the sync pass
  logic [8:0]  fq [$];                         // Expected queue contents
  logic [8:0]  w9, last;
  logic [7:0]  loc;
  int          errors, checked, dep, lvl, c;

  tprf_block i_dut (.SYS_CLK_IN(clk), .NRST_IN(rst_n), .PSEL_IN(psel), .PENABLE_IN(penable),
    .PWRITE_IN(pwrite), .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PRDATA_OUT(prdata),
    .PREADY_OUT(pready), .PSLVERR_OUT(pslverr), .WRITE_SIDE_CLOCK_IN(wclk),
    .READ_SIDE_CLOCK_IN(rclk), .WRITE_SELECT_N_IN(wsel_n), .WRITE_STROBE_N_IN(wstb_n),
    .WRITE_LOCATION_IN(wloc), .WRITE_WORD_IN(word), .READ_SELECT_N_IN(rsel_n),
    .READ_STROBE_N_IN(rstb_n), .READ_LOCATION_IN(rloc), .POINTER_RESET_N_IN(ptr_rst_n),
    .CASCADE_WORD_IN(casc), .READ_WORD_OUT(rword), .READ_PARITY_FAULT_OUT(rpf),
    .WRITE_PARITY_FAULT_OUT(wpf), .FULL_OUT(full), .EMPTY_OUT(empty),
    .COUNT_AT_THRESHOLD_OUT(eq), .COUNT_AT_OR_ABOVE_THRESHOLD_OUT(geq));

  tprf_user_model i_user (.clk_in(clk), .wsel_n_out(wsel_n), .wstb_n_out(wstb_n),
    .wloc_out(wloc), .word_out(word), .wclk_out(wclk), .rsel_n_out(rsel_n),
    .rstb_n_out(rstb_n), .rloc_out(rloc), .rclk_out(rclk));

  // 25 MHz system clock
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////
  // Expectations: parity word, config word, status word
  function automatic logic [8:0] mk(input logic [7:0] d, input logic odd, input logic bad);
    return {^d ^ odd ^ bad, d};
  endfunction
  function automatic logic [31:0] cfgw(input logic [6:0] b, input logic [2:0] g,
                                       input logic [7:0] l);
    return {8'h00, l, 5'h00, g, 1'b0, b};
  endfunction
  function automatic logic [31:0] stw(input int n, input int d, input int l);
    return {7'h00, 9'(n), 10'h000, 2'h0, n >= l, n == l, n == 0, n == d};
  endfunction

  // Verdict, one place for the end of the run
  task automatic give_verdict;
    $display("errors=%0d checked=%0d", errors, checked);
    if (errors == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH %0t value %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_flag(input logic got, input logic exp);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH %0t flag %b expected %b", $time, got, exp);
    end
  endtask

  // APB transfer; request holds until ready is seen high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] rq, output logic re);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    // Slave sets the pace; a ready that never comes is left to the watchdog
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rq = prdata;
    re = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic cfg(input logic [31:0] v);
    apb(1'b1, tprf_pkg::CFG_OFS, v, q, e);
  endtask
  // Status register and pins against occupancy c
  task automatic stat;
    apb(1'b0, tprf_pkg::STAT_OFS, 32'h0000_0000, q, e);
    chk_val(q, stw(c, dep, lvl));
    chk_val({28'h000_0000, geq, eq, empty, full}, stw(c, dep, lvl) & 32'h0000_000f);
  endtask
  // Port access, then time for word, faults and flags to settle
  task automatic ux(input logic w, input logic r, input logic [7:0] wl, input logic [8:0] wd,
                    input logic [7:0] rl);
    i_user.access(w, r, wl, wd, rl);
    repeat (4) @(posedge clk);
  endtask

  // Watchdog: the whole sequence needs about 13000 cycles
  initial begin
    repeat (40000) @(posedge clk);
    errors++;
    give_verdict;
  end

  ////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    {rst_n, psel, penable, pwrite, paddr, pwdata} = '0;
    ptr_rst_n = 1'b1;
    casc = 9'h000;
    errors = 0;
    checked = 0;
    c = $urandom(67599);
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    // Reset state: memory mode, full depth, level zero
    dep = 256;
    lvl = 0;
    c = 0;
    apb(1'b0, tprf_pkg::CFG_OFS, 32'h0000_0000, q, e);
    chk_val(q, tprf_pkg::CFG_RST);
    stat;
    // Unmapped place errors out; status stays read only
    apb(1'b0, 12'h008, 32'h0000_0000, q, e);
    chk_flag(e, 1'b1);
    chk_val(q, 32'h0000_0000);
    apb(1'b1, tprf_pkg::STAT_OFS, 32'hffff_ffff, q, e);
    chk_flag(e, 1'b0);
    stat;
    // Memory mode, async ports: edge locations, both parity senses, bad parity
    for (int i = 0; i < 12; i++) begin
      loc = (i == 0) ? 8'h00 : (i == 1) ? 8'hff : 8'($urandom);
      w9 = mk(8'($urandom), i[0], i[1]);
      cfg(cfgw({1'b0, i[0], 5'h00}, 3'h7, 8'h00));
      ux(1'b1, 1'b0, loc, w9, 8'h00);
      chk_flag(wpf, i[1]);
      ux(1'b0, 1'b1, 8'h00, 9'h000, loc);
      chk_val(32'(rword), 32'(w9));
      chk_flag(rpf, i[1]);
    end
    // Same location read and written together returns the new word
    ux(1'b1, 1'b0, 8'h5a, 9'h055, 8'h00);
    ux(1'b1, 1'b1, 8'h5a, 9'h1a3, 8'h5a);
    chk_val(32'(rword), 32'h0000_01a3);
    // Sync ports: transparent, then pipelined lagging one read clock
    cfg(cfgw(7'h06, 3'h7, 8'h00));
    for (int k = 0; k < 4; k++) begin
      wv[k] = mk(8'($urandom), 1'b0, 1'b0);
      ux(1'b1, 1'b0, 8'(k + 16), wv[k], 8'h00);
    end
    for (int k = 0; k < 4; k++) begin
      ux(1'b0, 1'b1, 8'h00, 9'h000, 8'(k + 16));
      chk_val(32'(rword), 32'(wv[k]));
    end
    cfg(cfgw(7'h0e, 3'h7, 8'h00));
    for (int k = 0; k < 4; k++) begin
      ux(1'b0, 1'b1, 8'h00, 9'h000, 8'(k + 16));
      // First pipelined read still shows the last transparent word
      chk_val(32'(rword), 32'(wv[(k + 3) % 4]));
    end
    // Cascade mux passes the neighbouring block's word
    cfg(cfgw(7'h40, 3'h7, 8'h00));
    repeat (2) begin
      casc <= 9'($urandom);
      repeat (4) @(posedge clk);
      chk_val(32'(rword), 32'(casc));
    end
    // Queue mode with generated parity, every depth select, fill past full
    for (int lg = 0; lg < 8; lg++) begin
      dep = 2 << lg;
      lvl = dep - 1;
      cfg(cfgw({1'b0, lg[0], 5'h11}, 3'(lg), 8'(lvl)));
      ptr_rst_n <= 1'b0;
      @(posedge clk);
      ptr_rst_n <= 1'b1;
      fq.delete();
      c = 0;
      stat;
      for (int k = 0; k <= dep; k++) begin
        w9 = 9'($urandom);
        ux(1'b1, 1'b0, 8'h00, w9, 8'h00);
        if (c < dep) begin
          fq.push_back(mk(w9[7:0], lg[0], 1'b0));
          c++;
        end
        stat;
      end
      for (int k = 0; k <= dep; k++) begin
        ux(1'b0, 1'b1, 8'h00, 9'h000, 8'h00);
        if (c > 0) begin
          last = fq.pop_front();
          chk_val(32'(rword), 32'(last));
          c--;
        end else begin
          chk_val(32'(rword), 32'(last));
        end
        chk_flag(rpf, 1'b0);
        stat;
      end
    end
    // Write and read together leave the count unchanged
    ux(1'b1, 1'b0, 8'h00, 9'h012, 8'h00);
    ux(1'b1, 1'b0, 8'h00, 9'h034, 8'h00);
    ux(1'b1, 1'b1, 8'h00, 9'h056, 8'h00);
    c = 2;
    chk_val(32'(rword), 32'(mk(8'h12, 1'b1, 1'b0)));
    stat;
    // Pointer reset in mid-run empties the queue
    ptr_rst_n <= 1'b0;
    @(posedge clk);
    ptr_rst_n <= 1'b1;
    c = 0;
    stat;
    give_verdict;
  end
endmodule

// ===== tprf_mem.sv
`timescale 1ns/1ps
// 256 x 9 storage with one write port and one registered read port
module tprf_mem (
  input  wire logic clk_in,
  input  wire logic rst_n_in,
  tprf_mem_if.mem   port
);

  logic [8:0] mem_ff [0:255];   // Array, not reset
  logic [8:0] rdata_ff;         // Read word register

  ////////////////////////////////////////////////////////////////////////////
  // Write port
  always_ff @(posedge clk_in) begin
    if (port.we) begin
      mem_ff[port.write_location] <= port.wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read port; a colliding write is passed straight through
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rdata_ff <= 9'h000;
    end else if (port.re) begin
      // Array still holds the old word this cycle, so bypass it
      if (port.we && (port.write_location == port.read_location)) begin
        rdata_ff <= port.wdata;   // R16
      end else begin
        rdata_ff <= mem_ff[port.read_location];
      end
    end
  end

  assign port.rdata = rdata_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  a_collide_bypass: assert property (@(posedge clk_in) disable iff (!rst_n_in) // R16
    (port.re && port.we && port.write_location == port.read_location) |=> (rdata_ff == $past(port.wdata)))
    else $error("Colliding read did not return write data");

endmodule

// ===== tprf_mem_if.sv
`timescale 1ns/1ps
// Carrier between queue control and the storage array
interface tprf_mem_if;
  logic       we;       // Write this cycle
  logic [7:0] write_location;    // Write location
  logic [8:0] wdata;    // Word to store
  logic       re;       // Read this cycle
  logic [7:0] read_location;    // Read location
  logic [8:0] rdata;    // Registered read word

  modport ctl (output we, output write_location, output wdata, output re, output read_location, input rdata);
  modport mem (input we, input write_location, input wdata, input re, input read_location, output rdata);
endinterface

// ===== tprf_pkg.sv
// Shared constants for the two-port memory / queue block
package tprf_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Storage geometry
  localparam int DATA_W = 9;                 // Word width, bit 8 is parity
  localparam int ADDR_W = 8;                 // 256 locations
  localparam int CNT_W  = 9;                 // Occupancy 0..256
  localparam int PAR_B  = 8;                 // Parity bit position

  ////////////////////////////////////////////////////////////////////////////
  // Register map (byte addresses on the bus)
  localparam int           APB_AW   = 12;
  localparam logic [11:0]  CFG_OFS  = 12'h000;   // Configuration, read/write
  localparam logic [11:0]  STAT_OFS = 12'h004;   // Status, read only

  // Configuration fields
  localparam int CFG_FIFO  = 0;    // 1 = queue, 0 = random access
  localparam int CFG_WSYNC = 1;    // Write port timed by write clock
  localparam int CFG_RSYNC = 2;    // Read port timed by read clock
  localparam int CFG_PIPE  = 3;    // Pipelined read (sync read only)
  localparam int CFG_PGEN  = 4;    // Generate parity instead of checking
  localparam int CFG_ODD   = 5;    // Odd parity when set
  localparam int CFG_CASC  = 6;    // Output mux takes cascade word
  localparam int CFG_LG    = 8;    // Depth select, 3 bits
  localparam int CFG_LVL   = 16;   // Threshold level, 8 bits
  localparam logic [31:0] CFG_RST = 32'h0000_0700;  // Full depth, RAM mode

  // Status fields
  localparam int ST_FULL  = 0;
  localparam int ST_EMPTY = 1;
  localparam int ST_EQ    = 2;
  localparam int ST_GEQ   = 3;
  localparam int ST_RFLT  = 4;
  localparam int ST_WFLT  = 5;
  localparam int ST_CNT   = 16;    // Occupancy, 9 bits

endpackage

// ===== tprf_user_model.sv
`timescale 1ns/1ps
// Fabric-side user logic that drives both memory ports
module tprf_user_model (
  input  wire logic       clk_in,
  output logic            wsel_n_out,
  output logic            wstb_n_out,
  output logic [7:0]      wloc_out,
  output logic [8:0]      word_out,
  output logic            wclk_out,
  output logic            rsel_n_out,
  output logic            rstb_n_out,
  output logic [7:0]      rloc_out,
  output logic            rclk_out
);
  ////////////////////////////////////////////////////////////
  // Idle: both ports deselected, port clocks standing low
  initial begin
    wsel_n_out = 1'b1;
    wstb_n_out = 1'b1;
    wloc_out   = 8'h00;
    word_out   = 9'h000;
    wclk_out   = 1'b0;
    rsel_n_out = 1'b1;
    rstb_n_out = 1'b1;
    rloc_out   = 8'h00;
    rclk_out   = 1'b0;
  end

  ////////////////////////////////////////////////////////////
  // One access: select and strobe low two cycles, port clock rises in the second
  // Same task serves async ports (taken at first low cycle) and sync ports
  task automatic access(input logic w, input logic r, input logic [7:0] wl,
                        input logic [8:0] wd, input logic [7:0] rl);
    @(posedge clk_in);
    if (w) begin
      wsel_n_out <= 1'b0;
      wstb_n_out <= 1'b0;
      wloc_out   <= wl;
      word_out   <= wd;
    end
    if (r) begin
      rsel_n_out <= 1'b0;
      rstb_n_out <= 1'b0;
      rloc_out   <= rl;
    end
    @(posedge clk_in);
    wclk_out <= w;
    rclk_out <= r;
    @(posedge clk_in);
    // Released lines flip so a stale value never passes for live data
    wsel_n_out <= 1'b1;
    wstb_n_out <= 1'b1;
    rsel_n_out <= 1'b1;
    rstb_n_out <= 1'b1;
    wloc_out   <= ~wloc_out;
    word_out   <= ~word_out;
    rloc_out   <= ~rloc_out;
    wclk_out   <= 1'b0;
    rclk_out   <= 1'b0;
    // Strobes stay high at least one cycle before the next access
    @(posedge clk_in);
  endtask
endmodule
